// ### cmu_pkg.sv
// Constants, register map and carrier types of the clock monitor
package cmu_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int FREQ_W = 12;
  localparam int SETTLE_COUNT_VALUE_W = 8;
  localparam int RCCTL_W = 4;

  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_RCCTL = 8'h00;
  localparam logic [7:0] OFF_FDISP = 8'h04;
  localparam logic [7:0] OFF_FRH   = 8'h08;
  localparam logic [7:0] OFF_FRL   = 8'h0c;
  localparam logic [7:0] OFF_CTRL  = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;
  localparam logic [7:0] OFF_SETTLE_COUNT_VALUE  = 8'h18;
  localparam logic [7:0] OFF_WE    = 8'h1c;
  localparam logic [7:0] OFF_IEN   = 8'h20;

  // Control register fields
  localparam int CTRL_MAIN_SEL  = 0;
  localparam int CTRL_METER_SEL = 1;
  localparam int CTRL_MON_SEL   = 2;
  localparam int CTRL_REN       = 3;
  localparam int CTRL_SFM       = 4;
  localparam int CTRL_RCSS      = 5;
  localparam int CTRL_RCHSE     = 6;
  localparam int CTRL_RC_STOP_LOW_FREQ      = 7;
  localparam int CTRL_RC_RUN_LOW_FREQ      = 8;
  localparam int CTRL_CRFR      = 9;
  localparam int CTRL_OSCS      = 10;

  // Status and interrupt enable fields
  localparam int ST_SETTLE   = 0;
  localparam int ST_LOSS     = 1;
  localparam int ST_OVER     = 2;
  localparam int ST_UNDER    = 3;
  localparam int ST_MRF      = 4;
  localparam int ST_OUT_MUX  = 5;
  localparam int ST_MET_MUX  = 6;
  localparam int ST_MON_MUX  = 7;
  localparam int NUM_FLAGS   = 4;

  // Reset values
  localparam logic [RCCTL_W-1:0] RST_RCCTL = 4'h8;
  localparam logic [FREQ_W-1:0]  RST_FRH   = 12'hfff;
  localparam logic [FREQ_W-1:0]  RST_FRL   = 12'h000;
  localparam logic [SETTLE_COUNT_VALUE_W-1:0]  RST_SETTLE_COUNT_VALUE  = 8'h4e;

  // Unlock keywords (arbitrary values)
  localparam logic [DATA_W-1:0] KEY_FIRST  = 16'h5a3c;
  localparam logic [DATA_W-1:0] KEY_SECOND = 16'ha5c3;

  // Timing counts
  localparam int SETTLE_MULT    = 512;
  localparam int SETTLE_SHIFT   = 9;
  localparam int WAKE_RC_CYCLES = 400;
  localparam int WINDOW_PULSES  = 16;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } cmu_bus_req_t;

  typedef enum logic [1:0] {
    CMU_LOCKED,
    CMU_KEY1_SEEN,
    CMU_OPEN
  } cmu_lock_t;

  typedef enum logic {
    CMU_SW_FOLLOW,
    CMU_SW_PARKED
  } cmu_sw_state_t;
endpackage

// ### cmu_rate_counter.sv
// Counts edges of one clock over a window of base-clock pulses
module cmu_rate_counter #(
  parameter int CNT_W  = 12,
  parameter int WINDOW = 16
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  // Control
  input  wire logic             restart,
  input  wire logic             base_edge,
  input  wire logic             meas_edge,
  // Result
  output logic [CNT_W-1:0]      count_q,
  output logic                  done_q
);
  localparam int WIN_W = $clog2(WINDOW + 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WINDOW);
  localparam logic [CNT_W-1:0] CNT_MAX  = '1;

  if (WINDOW < 1 || CNT_W < 2) begin : g_bad
    $error("cmu_rate_counter: unsupported parameters");
  end

  logic [WIN_W-1:0] base_q;
  logic [CNT_W-1:0] acc_q;
  logic             run_q;
  wire              win_end = base_edge && (base_q == WIN_LAST - 1'b1);
  // Saturate so a very fast clock reads as full scale, not wrapped
  wire  [CNT_W-1:0] acc_inc = (acc_q == CNT_MAX) ? acc_q : acc_q + 1'b1;
  wire  [CNT_W-1:0] acc_nxt = meas_edge ? acc_inc : acc_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      base_q  <= '0;
      acc_q   <= '0;
      count_q <= '0;
      done_q  <= 1'b0;
      run_q   <= 1'b0;
    end else if (restart) begin
      base_q  <= '0;
      acc_q   <= '0;
      done_q  <= 1'b0;
      run_q   <= 1'b0;
    end else if (!run_q) begin
      // Open on a base edge so the window spans whole base periods
      done_q <= 1'b0;
      run_q  <= base_edge;
    end else begin
      done_q <= win_end;
      if (win_end) begin
        base_q  <= '0;
        acc_q   <= '0;
        count_q <= acc_nxt;
      end else begin
        base_q <= base_edge ? base_q + 1'b1 : base_q;
        acc_q  <= acc_nxt;
      end
    end
  end
endmodule

// ### cmu_clock_monitor.sv
// Clock monitor: source selection, failure checks, meter and registers
// Function
// - Power-on forwards RC oscillator at 2 MHz
// - Wake from stop/halt forwards RC oscillator
// - Settling-done interrupt after programmable delay
// - RC oscillator drives wake-up timer directly
// - RC high setting after reset and wake
// - Separate run and stop RC frequency bits
// - Resume 400 RC cycles after wake
// - Two oscillators in, one clock out
// - Two unlock keywords before each write
// - Count 512 times settle value, set done
// - Settle done in reset selects main oscillator
// - Software moves output clock either way
// - Slow main oscillator falls back to RC
// - Over-frequency or stopped clock flags, resets
// - Under-frequency sets flag and interrupt
// - Start bit measures oscillator or PLL, self-clears
// - Meter and checker run from selected clock
// - Status bits show each multiplexer's clock
// - Result is sixteen times clock ratio
// - Monitor select: 0 RC, 1 main oscillator
// - Meter select: 0 main oscillator, 1 PLL
module cmu_clock_monitor
  import cmu_pkg::*;
#(
  parameter int SETTLE_COUNT_VALUE_BITS = cmu_pkg::SETTLE_COUNT_VALUE_W
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  // Register port
  input  wire cmu_pkg::cmu_bus_req_t bus_req,
  output logic [cmu_pkg::DATA_W-1:0] rdata_q,
  // Sampled clock sources
  input  wire logic                  osc_in,
  input  wire logic                  rc_in,
  input  wire logic                  mclk_in,
  input  wire logic                  pll_in,
  // System state
  input  wire logic                  sys_reset_active,
  input  wire logic                  stop_mode,
  input  wire logic                  wake_event,
  // Clock outputs
  output logic                       monitor_output_clock,
  output logic                       wakeup_timer_clk,
  // Oscillator control
  output logic                       rc_low_freq,
  output logic [cmu_pkg::RCCTL_W-1:0] rc_trim,
  output logic                       osc_stop,
  output logic                       rc_stop,
  // System requests
  output logic                       cpu_resume,
  output logic                       monitor_reset_req,
  // Interrupts
  output logic                       irq_settle,
  output logic                       irq_osc_loss,
  output logic                       irq_over,
  output logic                       irq_under
);
  import cmu_pkg::*;

  if (SETTLE_COUNT_VALUE_BITS != SETTLE_COUNT_VALUE_W) begin : g_bad
    $error("cmu_clock_monitor: settle count width must match map");
  end

  localparam int SET_W  = SETTLE_COUNT_VALUE_W + SETTLE_SHIFT;
  localparam int WAKE_W = $clog2(WAKE_RC_CYCLES + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_RC_CYCLES);
  localparam logic [FREQ_W-1:0] WIN_CNT   = FREQ_W'(WINDOW_PULSES);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // Edge detection on the sampled sources
  logic osc_p_q, rc_p_q, mclk_p_q, pll_p_q;
  wire  osc_rise  = osc_in && !osc_p_q;
  wire  rc_rise   = rc_in && !rc_p_q;
  wire  mclk_rise = mclk_in && !mclk_p_q;
  wire  pll_rise  = pll_in && !pll_p_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      osc_p_q  <= 1'b0;
      rc_p_q   <= 1'b0;
      mclk_p_q <= 1'b0;
      pll_p_q  <= 1'b0;
    end else begin
      osc_p_q  <= osc_in;
      rc_p_q   <= rc_in;
      mclk_p_q <= mclk_in;
      pll_p_q  <= pll_in;
    end
  end

  // Registers
  logic [RCCTL_W-1:0]   rcctl_q;
  logic [FREQ_W-1:0]    fdisp_q, frh_q, frl_q;
  logic [SETTLE_COUNT_VALUE_W-1:0]    settle_count_value_q;
  logic [NUM_FLAGS-1:0] ien_q, flags_q;
  logic                 mrf_q;
  logic main_sel_q, meter_sel_q, mon_sel_q, ren_q, sfm_q;
  logic rcss_q, rchse_q, rc_stop_low_freq_q, rc_run_low_freq_q, oscs_q;
  cmu_lock_t            lock_q;

  // Write decode
  wire [DATA_W-1:0] wd      = bus_req.wdata;
  wire              we_hit  = bus_req.wr && hit(bus_req.addr, OFF_WE);
  wire              wr_ok   = bus_req.wr && (lock_q == CMU_OPEN) && !we_hit;
  wire              w_rcctl = wr_ok && hit(bus_req.addr, OFF_RCCTL);
  wire              w_frh   = wr_ok && hit(bus_req.addr, OFF_FRH);
  wire              w_frl   = wr_ok && hit(bus_req.addr, OFF_FRL);
  wire              w_ctrl  = wr_ok && hit(bus_req.addr, OFF_CTRL);
  wire              w_stat  = wr_ok && hit(bus_req.addr, OFF_STAT);
  wire              w_settle_count_value  = wr_ok && hit(bus_req.addr, OFF_SETTLE_COUNT_VALUE);
  wire              w_ien   = wr_ok && hit(bus_req.addr, OFF_IEN);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      lock_q <= CMU_LOCKED;
    end else if (bus_req.wr) begin
      unique case (lock_q)
        CMU_LOCKED:
          lock_q <= (we_hit && wd == KEY_FIRST) ? CMU_KEY1_SEEN : CMU_LOCKED;
        CMU_KEY1_SEEN:
          lock_q <= (we_hit && wd == KEY_SECOND) ? CMU_OPEN : CMU_LOCKED;
        CMU_OPEN:
          lock_q <= (we_hit && wd == KEY_FIRST) ? CMU_KEY1_SEEN : CMU_LOCKED;
      endcase
    end
  end

  logic [SET_W-1:0] settle_cnt_q;
  logic             settle_done_q;
  wire  [SET_W-1:0] settle_n   = {settle_count_value_q, {SETTLE_SHIFT{1'b0}}};
  wire              settle_hit = !settle_done_q &&
                                 (settle_cnt_q >= settle_n);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      settle_cnt_q  <= '0;
      settle_done_q <= 1'b0;
    end else if (wake_event) begin
      settle_cnt_q  <= '0;
      settle_done_q <= 1'b0;
    end else if (settle_hit) begin
      settle_done_q <= 1'b1;
    end else if (!settle_done_q && osc_rise) begin
      settle_cnt_q <= settle_cnt_q + 1'b1;
    end
  end

  // Monitor logic base clock, 0 selects RC
  wire mon_edge  = mon_sel_q ? osc_rise : rc_rise;
  // Meter source: 0 main oscillator, 1 PLL
  wire met_edge  = meter_sel_q ? pll_rise : osc_rise;

  logic [FREQ_W-1:0] met_cnt, chk_cnt, loss_cnt;
  logic              met_done, chk_done, loss_done;

  // Meter window restarts on a start request
  wire sfm_set = w_ctrl && wd[CTRL_SFM] && !sfm_q;

  cmu_rate_counter #(.CNT_W(FREQ_W), .WINDOW(WINDOW_PULSES)) u_meter (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .restart   (!sfm_q),
    .base_edge (mon_edge),
    .meas_edge (met_edge),
    .count_q   (met_cnt),
    .done_q    (met_done)
  );

  cmu_rate_counter #(.CNT_W(FREQ_W), .WINDOW(WINDOW_PULSES)) u_checker (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .restart   (1'b0),
    .base_edge (mon_edge),
    .meas_edge (mclk_rise),
    .count_q   (chk_cnt),
    .done_q    (chk_done)
  );

  // Main oscillator measured against the RC window
  cmu_rate_counter #(.CNT_W(FREQ_W), .WINDOW(WINDOW_PULSES)) u_loss (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .restart   (1'b0),
    .base_edge (rc_rise),
    .meas_edge (osc_rise),
    .count_q   (loss_cnt),
    .done_q    (loss_done)
  );

  // Glitch-free output multiplexer state
  cmu_sw_state_t sw_q;
  logic          out_src_q;

  // Main oscillator not faster than RC while forwarded
  wire loss_ev  = loss_done && out_src_q && (loss_cnt <= WIN_CNT);
  // Above high limit, or no system clock at all
  wire over_ev  = chk_done && (chk_cnt > frh_q || chk_cnt == '0);
  wire under_ev = chk_done && (chk_cnt < frl_q);
  // Automatic switch while system reset still held
  wire auto_sel = settle_hit && sys_reset_active;

  // Hardware sets win over a software clear in the same cycle
  wire [NUM_FLAGS-1:0] flag_set = {under_ev, over_ev, loss_ev, settle_hit};
  wire [NUM_FLAGS-1:0] flag_clr = w_stat ? wd[NUM_FLAGS-1:0] : '0;
  wire [NUM_FLAGS-1:0] flags_d  = (flags_q & ~flag_clr) | flag_set;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rcctl_q <= RST_RCCTL;
      frh_q   <= RST_FRH;
      frl_q   <= RST_FRL;
      settle_count_value_q  <= RST_SETTLE_COUNT_VALUE;
      ien_q   <= '0;
    end else begin
      if (w_rcctl) rcctl_q <= wd[RCCTL_W-1:0];
      if (w_frh)   frh_q   <= wd[FREQ_W-1:0];
      if (w_frl)   frl_q   <= wd[FREQ_W-1:0];
      if (w_settle_count_value)  settle_count_value_q  <= wd[SETTLE_COUNT_VALUE_W-1:0];
      if (w_ien)   ien_q   <= wd[NUM_FLAGS-1:0];
    end
  end

  // Status flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flags_q <= '0;
      mrf_q   <= 1'b0;
    end else begin
      flags_q <= flags_d;
      // Monitor reset flag, cleared by its clear bit
      if (over_ev)
        mrf_q <= 1'b1;
      else if (w_ctrl && wd[CTRL_CRFR])
        mrf_q <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      main_sel_q  <= 1'b0;
      meter_sel_q <= 1'b0;
      mon_sel_q   <= 1'b0;
      ren_q       <= 1'b0;
      sfm_q       <= 1'b0;
      rcss_q      <= 1'b0;
      rchse_q     <= 1'b0;
      rc_stop_low_freq_q      <= 1'b0;
      rc_run_low_freq_q      <= 1'b0;
      oscs_q      <= 1'b0;
    end else begin
      if (w_ctrl) begin
        meter_sel_q <= wd[CTRL_METER_SEL];
        mon_sel_q   <= wd[CTRL_MON_SEL];
        ren_q       <= wd[CTRL_REN];
        rcss_q      <= wd[CTRL_RCSS];
        rchse_q     <= wd[CTRL_RCHSE];
        rc_stop_low_freq_q      <= wd[CTRL_RC_STOP_LOW_FREQ];
        rc_run_low_freq_q      <= wd[CTRL_RC_RUN_LOW_FREQ];
        oscs_q      <= wd[CTRL_OSCS];
      end
      // Wake or loss force RC; then
      if (wake_event || loss_ev)
        main_sel_q <= 1'b0;
      else if (auto_sel)
        main_sel_q <= 1'b1;
      else if (w_ctrl)
        main_sel_q <= wd[CTRL_MAIN_SEL];
      // Start bit clears when the result lands
      if (met_done && sfm_q)
        sfm_q <= 1'b0;
      else if (sfm_set)
        sfm_q <= 1'b1;
      // Run low-frequency bit cleared in stop, stop low-frequency bit after wake
      if (stop_mode) begin
        rcss_q <= 1'b0;
        rc_run_low_freq_q <= 1'b0;
      end
      if (wake_event) begin
        rc_stop_low_freq_q  <= 1'b0;
        rchse_q <= 1'b0;
        oscs_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      fdisp_q <= '0;
    else if (met_done && sfm_q)
      fdisp_q <= met_cnt;
  end

  // Park the output low, then adopt the new source at its low
  wire cur_lvl = out_src_q ? osc_in : rc_in;
  wire new_lvl = main_sel_q ? osc_in : rc_in;
  wire park    = (sw_q == CMU_SW_FOLLOW) && (main_sel_q != out_src_q) &&
                 !cur_lvl;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sw_q      <= CMU_SW_FOLLOW;
      out_src_q <= 1'b0;
    end else begin
      unique case (sw_q)
        CMU_SW_FOLLOW:
          if (park) sw_q <= CMU_SW_PARKED;
        CMU_SW_PARKED:
          if (!new_lvl) begin
            out_src_q <= main_sel_q;
            sw_q      <= CMU_SW_FOLLOW;
          end
      endcase
    end
  end

  // Single output clock from the two oscillators
  wire out_clk_d = (sw_q == CMU_SW_FOLLOW) && !park && cur_lvl;

  // Wake-up delay counted in RC cycles
  logic [WAKE_W-1:0] wake_cnt_q;
  logic              waking_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wake_cnt_q <= '0;
      waking_q   <= 1'b0;
    end else if (wake_event) begin
      wake_cnt_q <= '0;
      waking_q   <= 1'b1;
    end else if (waking_q && rc_rise) begin
      wake_cnt_q <= wake_cnt_q + 1'b1;
      if (wake_cnt_q == WAKE_LAST - 1'b1)
        waking_q <= 1'b0;
    end
  end

  // Read mux
  wire out_mux_rc = (sw_q == CMU_SW_FOLLOW) && out_src_q;
  logic [DATA_W-1:0] ctrl_rd, stat_rd, rd_mux;
  assign ctrl_rd = DATA_W'({oscs_q, 1'b0, rc_run_low_freq_q, rc_stop_low_freq_q, rchse_q, rcss_q,
                            sfm_q, ren_q, mon_sel_q, meter_sel_q,
                            main_sel_q});
  assign stat_rd = DATA_W'({mon_sel_q, meter_sel_q, out_mux_rc, mrf_q,
                            flags_q});
  assign rd_mux  =
    hit(bus_req.addr, OFF_RCCTL) ? DATA_W'(rcctl_q) :
    hit(bus_req.addr, OFF_FDISP) ? DATA_W'(fdisp_q) :
    hit(bus_req.addr, OFF_FRH)   ? DATA_W'(frh_q)   :
    hit(bus_req.addr, OFF_FRL)   ? DATA_W'(frl_q)   :
    hit(bus_req.addr, OFF_CTRL)  ? ctrl_rd          :
    hit(bus_req.addr, OFF_STAT)  ? stat_rd          :
    hit(bus_req.addr, OFF_SETTLE_COUNT_VALUE)  ? DATA_W'(settle_count_value_q)  :
    hit(bus_req.addr, OFF_IEN)   ? DATA_W'(ien_q)   : '0;

  // Registered outputs
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q              <= '0;
      monitor_output_clock <= 1'b0;
      wakeup_timer_clk     <= 1'b0;
      rc_low_freq          <= 1'b0;
      rc_trim              <= RST_RCCTL;
      osc_stop             <= 1'b0;
      rc_stop              <= 1'b0;
      cpu_resume           <= 1'b1;
      monitor_reset_req    <= 1'b0;
      irq_settle           <= 1'b0;
      irq_osc_loss         <= 1'b0;
      irq_over             <= 1'b0;
      irq_under            <= 1'b0;
    end else begin
      rdata_q              <= bus_req.rd ? rd_mux : '0;
      monitor_output_clock <= out_clk_d;
      // Wake-up timer sees the RC oscillator unmuxed
      wakeup_timer_clk     <= rc_in;
      // Stop setting in stop mode, run setting otherwise
      rc_low_freq          <= stop_mode ? rc_stop_low_freq_q : rc_run_low_freq_q;
      rc_trim              <= rcctl_q;
      osc_stop             <= oscs_q && !out_src_q;
      rc_stop              <= (rcss_q && out_src_q) ||
                              (rchse_q && stop_mode);
      // Execution held until the delay ends
      cpu_resume           <= !waking_q && !wake_event;
      monitor_reset_req    <= over_ev && ren_q;
      irq_settle           <= flags_d[ST_SETTLE] && ien_q[ST_SETTLE];
      irq_osc_loss         <= flags_d[ST_LOSS] && ien_q[ST_LOSS];
      irq_over             <= flags_d[ST_OVER] && ien_q[ST_OVER];
      irq_under            <= flags_d[ST_UNDER] && ien_q[ST_UNDER];
    end
  end
endmodule

// ### cmu_clk_src.sv
// Model of the clock sources around the monitor
module cmu_clk_src (
  // Clock
  input  wire logic        ref_clk,
  // Half periods: rc, osc, mclk, pll; zero holds low
  input  wire logic [31:0] half_cfg,
  // Generated clocks
  output logic      [3:0]  clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt_q [4] = '{default: 8'h00};
  initial clk_o = 4'h0;
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (half_cfg[i*8+:8] == 8'h00) begin
        clk_o[i] <= 1'b0;
        cnt_q[i] <= 8'h00;
      end else if (cnt_q[i] >= half_cfg[i*8+:8] - 8'h01) begin
        clk_o[i] <= ~clk_o[i];
        cnt_q[i] <= 8'h00;
      end else begin
        cnt_q[i] <= cnt_q[i] + 8'h01;
      end
    end
  end
endmodule

// ### cmu_clock_monitor_asserts.sv
// Port checker of the clock monitor
module cmu_clock_monitor_asserts
  import cmu_pkg::*;
(
  // Clock and reset
  input wire logic                      ref_clk,
  input wire logic                      nrst,
  // Inputs
  input wire cmu_pkg::cmu_bus_req_t     bus_req,
  input wire logic                      rc_in,
  input wire logic                      wake_event,
  // Outputs
  input wire logic [cmu_pkg::DATA_W-1:0] rdata_q,
  input wire logic                      monitor_output_clock,
  input wire logic                      wakeup_timer_clk,
  input wire logic [cmu_pkg::RCCTL_W-1:0] rc_trim,
  input wire logic                      cpu_resume,
  input wire logic                      monitor_reset_req
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic       rc_q;
  logic [9:0] rc_cnt_q;
  wire        rc_rise = rc_in & ~rc_q;
  // Rc rises since the last wake request, saturating
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rc_q <= 1'b0;
      rc_cnt_q <= 10'h000;
    end else begin
      rc_q <= rc_in;
      if (wake_event) begin
        rc_cnt_q <= 10'h000;
      end else if (rc_rise && rc_cnt_q != 10'h3ff) begin
        rc_cnt_q <= rc_cnt_q + 10'h001;
      end
    end
  end
  sequence s_wake_taken;
    wake_event ##1 !cpu_resume;
  endsequence
  chk_wake_holds: assert property (
    s_wake_taken |=> !cpu_resume[*7]) else $error("resume too early");
  chk_resume_count: assert property (
    $rose(cpu_resume) |-> rc_cnt_q inside {[10'h18f:10'h192]})
    else $error("resume not after 400 rc cycles");
  chk_rd_idle: assert property (
    !bus_req.rd |=> rdata_q == '0) else $error("read data outside slot");
  chk_trim_hold: assert property (
    !bus_req.wr ##1 !bus_req.wr |=> $stable(rc_trim))
    else $error("trim changed unasked");
  chk_out_rise: assert property (
    $rose(monitor_output_clock) |=> monitor_output_clock)
    else $error("short high pulse");
  chk_out_fall: assert property (
    $fell(monitor_output_clock) |=> !monitor_output_clock)
    else $error("short low pulse");
  chk_timer_clk: assert property (
    nrst |=> wakeup_timer_clk == $past(rc_in)) else $error("timer clock");
  chk_reset_pulse: assert property (
    monitor_reset_req |=> !monitor_reset_req) else $error("reset pulse long");
endmodule
bind cmu_clock_monitor cmu_clock_monitor_asserts u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .bus_req(bus_req), .rc_in(rc_in),
  .wake_event(wake_event), .rdata_q(rdata_q),
  .monitor_output_clock(monitor_output_clock),
  .wakeup_timer_clk(wakeup_timer_clk), .rc_trim(rc_trim),
  .cpu_resume(cpu_resume), .monitor_reset_req(monitor_reset_req)
);

// ### testbench.sv
// Register-level testbench of the clock monitor
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import cmu_pkg::*;
  localparam int RC_H = 3;
  localparam int OSC_H = 2;
  localparam int PLL_H = 4;
  logic              ref_clk = 1'b0;
  logic              nrst = 1'b0;
  cmu_bus_req_t      req = '0;
  logic [15:0]       rdata_q;
  logic              sys_rst = 1'b0;
  logic              stop = 1'b0;
  logic              wake = 1'b0;
  logic [31:0]       half_cfg = 32'h04020203;
  logic [3:0]        src;
  logic              out_clk, tmr_clk, rc_low, osc_stop, rc_stop;
  logic              resume, mrr;
  logic [3:0]        trim;
  logic [3:0]        irq;
  logic [15:0]       d;
  int                err_total = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  always #25 ref_clk = ~ref_clk;
  cmu_clk_src u_src (.ref_clk(ref_clk), .half_cfg(half_cfg), .clk_o(src));
  cmu_clock_monitor dut (
    .ref_clk(ref_clk), .nrst(nrst), .bus_req(req), .rdata_q(rdata_q),
    .osc_in(src[1]), .rc_in(src[0]), .mclk_in(src[2]), .pll_in(src[3]),
    .sys_reset_active(sys_rst), .stop_mode(stop), .wake_event(wake),
    .monitor_output_clock(out_clk), .wakeup_timer_clk(tmr_clk),
    .rc_low_freq(rc_low), .rc_trim(trim), .osc_stop(osc_stop),
    .rc_stop(rc_stop), .cpu_resume(resume), .monitor_reset_req(mrr),
    .irq_settle(irq[0]), .irq_osc_loss(irq[1]), .irq_over(irq[2]),
    .irq_under(irq[3])
  );
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] v);
    @(posedge ref_clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask
  // Unlock keys go right before every protected write
  task automatic uw(logic [7:0] a, logic [15:0] v);
    wr(OFF_WE, KEY_FIRST);
    wr(OFF_WE, KEY_SECOND);
    wr(a, v);
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge ref_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  task automatic rchk(string nm, logic [7:0] a, logic [15:0] exp);
    rd(a);
    chk(nm, exp, d);
  endtask
  task automatic poll(logic [7:0] a, int b, logic v);
    for (int i = 0; i < 1500; i++) begin
      rd(a);
      if (d[b] === v) break;
    end
  endtask
  // Output must repeat the chosen source one cycle later
  task automatic follows(string nm, int s);
    logic p;
    #1;
    for (int i = 0; i < 12; i++) begin
      p = src[s];
      tick(1);
      chk(nm, p, out_clk);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    follows("out_rc", 0);
    chk("trim", RST_RCCTL, trim);
    chk("rc_low", 0, rc_low);
    rchk("frh", OFF_FRH, RST_FRH);
    rchk("settle_count_value", OFF_SETTLE_COUNT_VALUE, RST_SETTLE_COUNT_VALUE);
    rchk("stat", OFF_STAT, 16'h0000);
    rchk("unmapped", 8'h24, 16'h0000);
    wr(OFF_FRL, 16'h0123);
    wr(OFF_WE, KEY_FIRST);
    wr(OFF_SETTLE_COUNT_VALUE, 16'h0001);
    wr(OFF_WE, KEY_SECOND);
    wr(OFF_FRL, 16'h0123);
    rchk("frl_lock", OFF_FRL, 16'h0000);
    rchk("settle_count_value_lock", OFF_SETTLE_COUNT_VALUE, RST_SETTLE_COUNT_VALUE);
    uw(OFF_RCCTL, 16'h0005);
    wr(OFF_RCCTL, 16'h000a);
    rchk("trim_once", OFF_RCCTL, 16'h0005);
    uw(OFF_SETTLE_COUNT_VALUE, 16'h0001);
    uw(OFF_IEN, 16'h000f);
    uw(OFF_CTRL, 16'h05c0);
    tick(2);
    chk("run_low", 1, rc_low);
    chk("osc_stop", 1, osc_stop);
    @(posedge ref_clk);
    stop <= 1'b1;
    sys_rst <= 1'b1;
    tick(2);
    chk("stop_low", 1, rc_low);
    chk("rc_stop", 1, rc_stop);
    @(posedge ref_clk);
    wake <= 1'b1;
    stop <= 1'b0;
    @(posedge ref_clk);
    wake <= 1'b0;
    #1 chk("resume_off", 0, resume);
    tick(1);
    chk("wake_high", 0, rc_low);
    rchk("ctrl_wake", OFF_CTRL, 16'h0000);
    chk("osc_run", 0, osc_stop);
    tick(1900);
    chk("settle_early", 0, irq[0]);
    for (int i = 0; i < 3000 && resume !== 1'b1; i++) tick(1);
    chk("resume", 1, resume);
    poll(OFF_STAT, ST_SETTLE, 1'b1);
    chk("settle", 1, d[ST_SETTLE]);
    chk("irq_settle", 1, irq[0]);
    rd(OFF_CTRL);
    chk("auto_main", 1, d[CTRL_MAIN_SEL]);
    poll(OFF_STAT, ST_OUT_MUX, 1'b1);
    chk("mux_main", 1, d[ST_OUT_MUX]);
    follows("out_osc", 1);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    uw(OFF_STAT, 16'h0001);
    tick(2);
    chk("irq_settle_clr", 0, irq[0]);
    // Stop the oscillator while low so no forwarded pulse is cut
    @(negedge src[1]);
    @(posedge ref_clk);
    half_cfg[15:8] <= 8'h00;
    poll(OFF_STAT, ST_LOSS, 1'b1);
    chk("loss", 1, d[ST_LOSS]);
    chk("irq_loss", 1, irq[1]);
    rd(OFF_CTRL);
    chk("sel_forced", 0, d[CTRL_MAIN_SEL]);
    poll(OFF_STAT, ST_OUT_MUX, 1'b0);
    follows("out_back", 0);
    @(posedge ref_clk);
    half_cfg[15:8] <= 8'(OSC_H);
    // Let a loss window pass that still holds the stopped stretch
    tick(100);
    uw(OFF_STAT, 16'h0002);
    for (int s = 1; s >= 0; s--) begin
      uw(OFF_CTRL, 16'(s));
      poll(OFF_STAT, ST_OUT_MUX, s[0]);
      chk("sw_sel", 16'(s), d[ST_OUT_MUX]);
    end
    uw(OFF_CTRL, 16'h0008);
    @(posedge ref_clk);
    half_cfg[23:16] <= 8'h00;
    for (int i = 0; i < 600 && mrr !== 1'b1; i++) tick(1);
    chk("reset_req", 1, mrr);
    rd(OFF_STAT);
    chk("over", 1, d[ST_OVER]);
    chk("reset_flag", 1, d[ST_MRF]);
    chk("irq_over", 1, irq[2]);
    @(posedge ref_clk);
    half_cfg[23:16] <= 8'h02;
    tick(192);
    uw(OFF_CTRL, 16'h0200);
    uw(OFF_STAT, 16'h0004);
    rd(OFF_STAT);
    chk("flag_clr", 0, d[ST_MRF]);
    chk("irq_over_clr", 0, irq[2]);
    uw(OFF_FRL, 16'h0fff);
    poll(OFF_STAT, ST_UNDER, 1'b1);
    chk("under", 1, d[ST_UNDER]);
    chk("irq_under", 1, irq[3]);
    for (int s = 0; s < 2; s++) begin
      uw(OFF_CTRL, 16'h0010 | 16'(s << 1));
      poll(OFF_CTRL, CTRL_SFM, 1'b0);
      chk("sfm", 0, d[CTRL_SFM]);
      rchk("fdisp", OFF_FDISP, 16'(16 * RC_H / (s ? PLL_H : OSC_H)));
      rd(OFF_STAT);
      chk("meter_mux", 16'(s), d[ST_MET_MUX]);
    end
    uw(OFF_CTRL, 16'h0004);
    tick(192);
    uw(OFF_CTRL, 16'h0014);
    poll(OFF_CTRL, CTRL_SFM, 1'b0);
    rchk("fdisp_osc", OFF_FDISP, 16'd16);
    rd(OFF_STAT);
    chk("mon_mux", 1, d[ST_MON_MUX]);
    end_of_test();
  end
endmodule
